// file: design/sled_pkg.sv
// status indicator controller: shared constants, register map, source codes, states
// assumes a 125 MHz system clock; all widths here are fixed
package sled_pkg;

  // time base
  localparam int CLOCK_MHZ      = 125;
  localparam int TICK_MS        = 4;
  localparam int TICK_CYCLES    = TICK_MS * 1000 * CLOCK_MHZ;
  localparam int WINDOW_MS      = 640;
  localparam int WINDOW_TICKS   = WINDOW_MS / TICK_MS;
  localparam int GRADE_STEPS    = 10;
  localparam int GRADE_SHIFT    = 4;
  localparam int STEP_SHIFT_ON  = 4;
  localparam int STEP_SHIFT_OFF = 3;
  localparam int PHASE_W        = 12;

  // register map
  localparam logic [15:0] REG_BLINK_ADDR = 16'h8C81;
  localparam logic [15:0] REG_CTRL_ADDR  = 16'h8C82;
  localparam logic [15:0] BLINK_RESET    = 16'h3636;
  localparam logic [15:0] CTRL_RESET     = 16'h8480;
  localparam logic [15:0] READ_NONE      = 16'h0000;

  // field positions
  localparam int ON_MSB   = 15;
  localparam int ON_LSB   = 8;
  localparam int OFF_MSB  = 7;
  localparam int OFF_LSB  = 0;
  localparam int EN_BIT   = 15;
  localparam int QUAL_BIT = 14;
  localparam int MODE_BIT = 13;
  localparam int SRC_MSB  = 12;
  localparam int SRC_LSB  = 8;

  localparam logic [2:0] PINMUX_OFF = 3'h7;

  typedef enum logic [4:0] {
    SRC_LINK_ANY   = 5'h00,
    SRC_LINK_SEND  = 5'h01,
    SRC_LINK_RECV  = 5'h02,
    SRC_LINK_ALONE = 5'h03,
    SRC_ANY        = 5'h04,
    SRC_SEND       = 5'h05,
    SRC_RECV       = 5'h06,
    SRC_ON         = 5'h0D,
    SRC_OFF        = 5'h0E,
    SRC_BLINK      = 5'h0F,
    SRC_HIGH_SWING = 5'h10,
    SRC_LOW_SWING  = 5'h11,
    SRC_LEADER     = 5'h12,
    SRC_FOLLOWER   = 5'h13,
    SRC_MISMATCH   = 5'h14,
    SRC_NEG_GOOD   = 5'h15,
    SRC_NEG_DONE   = 5'h16,
    SRC_TRAIN_TMR  = 5'h17,
    SRC_LOC_RCVR   = 5'h18,
    SRC_REM_RCVR   = 5'h19,
    SRC_REF_CLK    = 5'h1A,
    SRC_TX_CLK     = 5'h1B,
    SRC_FAST_CLK   = 5'h1C,
    SRC_ROLE_FAULT = 5'h1D
  } sled_src_t;

  typedef enum logic [1:0] {
    ST_STEADY,
    ST_OFF,
    ST_ON
  } sled_state_t;

endpackage : sled_pkg

// file: design/sled_tick.sv
// status indicator controller: periodic time-base tick generator
// assumes one free-running system clock and synchronous reset
`timescale 1ns/10ps
module sled_tick #(
  parameter int CYCLES = sled_pkg::TICK_CYCLES
) (
  input  wire logic clock,
  input  wire logic reset,
  output logic      tick
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_ff;
  logic          tick_ff;
  wire           wrap = (cnt_ff == LAST);
  wire [CW-1:0]  nxt_cnt = wrap ? '0 : CW'(cnt_ff + 1'b1);

  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= wrap;
    end
  end

  assign tick = tick_ff;

endmodule : sled_tick

// file: design/sled_grader.sv
// status indicator controller: activity grader in tenths over a measurement window
// assumes tick is a one-cycle pulse from the time base, activity from the same clock
`timescale 1ns/10ps
module sled_grader (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       tick,
  input  wire logic       activity,
  output logic [3:0]      level
);

  localparam logic [7:0] WIN_LAST = 8'(sled_pkg::WINDOW_TICKS - 1);
  localparam logic [3:0] MAX_LVL  = 4'(sled_pkg::GRADE_STEPS);

  logic [7:0] win_ff;
  logic [7:0] busy_ff;
  logic       seen_ff;
  logic [3:0] level_ff;

  wire       win_end  = tick & (win_ff == WIN_LAST);
  wire [7:0] busy_inc = 8'(busy_ff + {7'h00, seen_ff | activity});
  wire [3:0] raw_lvl  = 4'(busy_inc >> sled_pkg::GRADE_SHIFT);
  wire [3:0] nxt_lvl  = (raw_lvl > MAX_LVL) ? MAX_LVL : raw_lvl;

  // activity between ticks is remembered so short bursts still count
  always_ff @(posedge clock) begin
    if (reset) begin
      win_ff   <= 8'h00;
      busy_ff  <= 8'h00;
      seen_ff  <= 1'b0;
      level_ff <= 4'h0;
    end else if (tick) begin
      win_ff   <= win_end ? 8'h00 : 8'(win_ff + 1'b1);
      busy_ff  <= win_end ? 8'h00 : busy_inc;
      seen_ff  <= 1'b0;
      level_ff <= win_end ? nxt_lvl : level_ff;
    end else begin
      seen_ff  <= seen_ff | activity;
    end
  end

  assign level = level_ff;

endmodule : sled_grader

// file: design/sled_ctrl.sv
// status indicator controller: register pair, source selection, blink engine, pin drive
// assumes status and activity inputs come from logic on the same clock,
// clock sources for pass-through arrive from other domains
`timescale 1ns/10ps

// Function
// - blinking on phase lasts on-time field times 4 ms
// - blinking off phase lasts off-time field times 4 ms
// - mode 0 with blink source: off phase first, then on, repeating
// - mode 1 with blink source: on phase first, then off, repeating
// - both times zero: pin follows selected activity signal live
// - link plus activity sources: on when link up idle, off otherwise
// - pure activity sources: off when idle, on with activity
// - on-time in bits 15:8, off-time 7:0, reset 0x36 each
// - enable bit 15, reset 1; cleared forces indicator off
// - qualify bit 14 gates swing and role indications with link
// - mode bit 13 clear: blink on activity at programmed rate
// - mode bit set: grade activity in tenths, longer off, shorter on
// - graded level re-evaluated after each 640 ms window
// - source selector field, reset 4, picks what drives the pin
// - codes 0 to 6 are link/traffic combinations in listed order
// - clock selections bypass blink logic and drive clock to pin
// - status selections drive pin statically from signal level
// - other selections are never gated with link status
// - pin not driven when its pin-mux select holds 111
module sled_ctrl #(
  parameter int TICK_CYCLES = sled_pkg::TICK_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        reset,
  // management register access
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr_en,
  output logic [15:0]      reg_rdata,
  // pin multiplexer select held elsewhere
  input  wire logic [2:0]  pinmux_select,
  // link and traffic status
  input  wire logic        link_up,
  input  wire logic        send_traffic,
  input  wire logic        recv_traffic,
  // static status indications
  input  wire logic        high_swing_level,
  input  wire logic        low_swing_level,
  input  wire logic        role_leader,
  input  wire logic        role_resolution_fault,
  input  wire logic        mismatched_link_setup,
  input  wire logic        negotiated_link_good,
  input  wire logic        negotiation_done,
  input  wire logic        training_timer_flag,
  input  wire logic        local_receiver_ok,
  input  wire logic        remote_receiver_ok,
  // clock sources for pass-through, foreign domains
  input  wire logic        ref_clock_out_src,
  input  wire logic        transmit_clock_out_src,
  input  wire logic        fast_clock_out_src,
  // indicator pin
  output logic             second_indicator_pin,
  output logic             second_indicator_pin_oe
);

  // registers
  logic [15:0] blink_ff;
  logic [15:0] ctrl_ff;
  logic [15:0] rdata_ff;

  // writes to any other address fall through silently
  wire         hit_blink = reg_wr_en & (reg_addr == sled_pkg::REG_BLINK_ADDR);
  wire         hit_ctrl  = reg_wr_en & (reg_addr == sled_pkg::REG_CTRL_ADDR);
  wire [15:0]  nxt_rdata = (reg_addr == sled_pkg::REG_BLINK_ADDR) ? blink_ff :
                           (reg_addr == sled_pkg::REG_CTRL_ADDR)  ? ctrl_ff  :
                           sled_pkg::READ_NONE;

  // each register keeps its own short process
  always_ff @(posedge clock) begin
    if (reset) begin
      blink_ff <= sled_pkg::BLINK_RESET;
    end else begin
      blink_ff <= hit_blink ? reg_wdata : blink_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_ff <= sled_pkg::CTRL_RESET;
    end else begin
      ctrl_ff <= hit_ctrl ? reg_wdata : ctrl_ff;
    end
  end

  // read data is registered, so it lags the address by one cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_ff <= sled_pkg::READ_NONE;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // field views
  wire [7:0] on_interval_ticks      = blink_ff[sled_pkg::ON_MSB:sled_pkg::ON_LSB];
  wire [7:0] off_interval_ticks     = blink_ff[sled_pkg::OFF_MSB:sled_pkg::OFF_LSB];
  wire       indicator_enable       = ctrl_ff[sled_pkg::EN_BIT];
  wire       gate_with_link_state   = ctrl_ff[sled_pkg::QUAL_BIT];
  wire       indicator_mode_select  = ctrl_ff[sled_pkg::MODE_BIT];
  wire [4:0] indicator_source_select = ctrl_ff[sled_pkg::SRC_MSB:sled_pkg::SRC_LSB];

  // clock pass-through sources are synchronised; only slow sources survive sampling
  logic [2:0] clk_meta_ff;
  logic [2:0] clk_sync_ff;
  wire  [2:0] clk_raw = {fast_clock_out_src, transmit_clock_out_src, ref_clock_out_src};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clock) begin
        if (reset) begin
          clk_meta_ff[gi] <= 1'b0;
          clk_sync_ff[gi] <= 1'b0;
        end else begin
          clk_meta_ff[gi] <= clk_raw[gi];
          clk_sync_ff[gi] <= clk_meta_ff[gi];
        end
      end
    end
  endgenerate

  // time base and activity grader
  logic       tick;
  logic [3:0] level;

  sled_tick #(
    .CYCLES   (TICK_CYCLES)
  ) u_tick (
    .clock    (clock),
    .reset    (reset),
    .tick     (tick)
  );

  // source decode
  wire any_traffic  = send_traffic | recv_traffic;
  wire sel_is_combo = (indicator_source_select == sled_pkg::SRC_LINK_ANY)  |
                      (indicator_source_select == sled_pkg::SRC_LINK_SEND) |
                      (indicator_source_select == sled_pkg::SRC_LINK_RECV) |
                      (indicator_source_select == sled_pkg::SRC_LINK_ALONE);
  wire sel_is_pure  = (indicator_source_select == sled_pkg::SRC_ANY)  |
                      (indicator_source_select == sled_pkg::SRC_SEND) |
                      (indicator_source_select == sled_pkg::SRC_RECV);
  wire sel_is_blink = (indicator_source_select == sled_pkg::SRC_BLINK);

  // selected traffic for the timed functions
  logic sel_traffic;
  always_comb begin
    unique case (indicator_source_select)
      sled_pkg::SRC_LINK_ANY,
      sled_pkg::SRC_ANY:       sel_traffic = any_traffic;
      sled_pkg::SRC_LINK_SEND,
      sled_pkg::SRC_SEND:      sel_traffic = send_traffic;
      sled_pkg::SRC_LINK_RECV,
      sled_pkg::SRC_RECV:      sel_traffic = recv_traffic;
      default:                 sel_traffic = 1'b0;
    endcase
  end

  sled_grader u_grader (
    .clock    (clock),
    .reset    (reset),
    .tick     (tick),
    .activity (sel_traffic),
    .level    (level)
  );

  // idle level and live level
  wire steady_level = sel_is_combo & link_up;
  wire live_level   = sel_is_combo ? (link_up & ~sel_traffic) : sel_traffic;
  wire times_zero   = (on_interval_ticks == 8'h00) & (off_interval_ticks == 8'h00);

  // phase counter width covers the longest graded off interval
  localparam int PW = sled_pkg::PHASE_W;

  // graded lengths: higher activity shortens on and lengthens off
  wire [PW-1:0] on_base   = PW'(on_interval_ticks);
  wire [PW-1:0] off_base  = PW'(off_interval_ticks);
  wire [PW-1:0] on_step   = PW'(on_interval_ticks >> sled_pkg::STEP_SHIFT_ON);
  wire [PW-1:0] off_step  = PW'(off_interval_ticks >> sled_pkg::STEP_SHIFT_OFF);
  wire [PW-1:0] on_cut    = PW'(PW'(level) * on_step);
  wire [PW-1:0] off_add   = PW'(PW'(level) * off_step);
  wire [PW-1:0] on_len    = indicator_mode_select ? PW'(on_base - on_cut) : on_base;
  wire [PW-1:0] off_len   = indicator_mode_select ? PW'(off_base + off_add) : off_base;

  // blink engine
  sled_pkg::sled_state_t state_ff;
  sled_pkg::sled_state_t nxt_state;
  logic [PW-1:0]         cnt_ff;
  logic [PW-1:0]         nxt_cnt;
  logic                  seen_ff;
  logic                  nxt_seen;

  wire timed    = sel_is_blink | ((sel_is_combo | sel_is_pure) & ~times_zero);
  wire want_run = sel_is_blink | sel_traffic;
  wire expired  = tick & (cnt_ff <= PW'(1));
  wire first_on = indicator_mode_select;
  // the cycle that ends a full off+on or on+off pair
  wire pair_end = expired & (((state_ff == sled_pkg::ST_ON)  & ~first_on) |
                             ((state_ff == sled_pkg::ST_OFF) &  first_on));

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = (tick && cnt_ff != '0) ? PW'(cnt_ff - 1'b1) : cnt_ff;
    nxt_seen  = seen_ff | sel_traffic;
    if (!timed) begin
      nxt_state = sled_pkg::ST_STEADY;
      nxt_cnt   = '0;
      nxt_seen  = 1'b0;
    end else begin
      unique case (state_ff)
        sled_pkg::ST_STEADY: begin
          if (want_run) begin
            nxt_state = first_on ? sled_pkg::ST_ON : sled_pkg::ST_OFF;
            nxt_cnt   = first_on ? on_len : off_len;
            nxt_seen  = sel_traffic;
          end
        end
        sled_pkg::ST_OFF: begin
          if (expired) begin
            if (pair_end && !(sel_is_blink || seen_ff || sel_traffic)) begin
              nxt_state = sled_pkg::ST_STEADY;
            end else begin
              nxt_state = sled_pkg::ST_ON;
              nxt_cnt   = on_len;
            end
            nxt_seen  = pair_end ? sel_traffic : nxt_seen;
          end
        end
        sled_pkg::ST_ON: begin
          if (expired) begin
            if (pair_end && !(sel_is_blink || seen_ff || sel_traffic)) begin
              nxt_state = sled_pkg::ST_STEADY;
            end else begin
              nxt_state = sled_pkg::ST_OFF;
              nxt_cnt   = off_len;
            end
            nxt_seen  = pair_end ? sel_traffic : nxt_seen;
          end
        end
        default: begin
          nxt_state = sled_pkg::ST_STEADY;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_ff <= sled_pkg::ST_STEADY;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // counter moves on ticks only: a first interval may run short by one tick
  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      seen_ff <= 1'b0;
    end else begin
      seen_ff <= nxt_seen;
    end
  end

  wire blink_level = (state_ff == sled_pkg::ST_ON)  ? 1'b1 :
                     (state_ff == sled_pkg::ST_OFF) ? 1'b0 :
                     steady_level;

  // only swing and role indications may be link gated
  wire qual = ~gate_with_link_state | link_up;

  // one source per code; unused codes leave the pin dark
  logic src_level;
  always_comb begin
    unique case (indicator_source_select)
      sled_pkg::SRC_LINK_ANY,
      sled_pkg::SRC_LINK_SEND,
      sled_pkg::SRC_LINK_RECV,
      sled_pkg::SRC_LINK_ALONE,
      sled_pkg::SRC_ANY,
      sled_pkg::SRC_SEND,
      sled_pkg::SRC_RECV:       src_level = times_zero ? live_level : blink_level;
      sled_pkg::SRC_ON:         src_level = 1'b1;
      sled_pkg::SRC_OFF:        src_level = 1'b0;
      sled_pkg::SRC_BLINK:      src_level = times_zero ? 1'b1 : blink_level;
      sled_pkg::SRC_HIGH_SWING: src_level = high_swing_level & qual;
      sled_pkg::SRC_LOW_SWING:  src_level = low_swing_level & qual;
      sled_pkg::SRC_LEADER:     src_level = role_leader & qual;
      sled_pkg::SRC_FOLLOWER:   src_level = ~role_leader & qual;
      sled_pkg::SRC_ROLE_FAULT: src_level = role_resolution_fault;
      sled_pkg::SRC_MISMATCH:   src_level = mismatched_link_setup;
      sled_pkg::SRC_NEG_GOOD:   src_level = negotiated_link_good;
      sled_pkg::SRC_NEG_DONE:   src_level = negotiation_done;
      sled_pkg::SRC_TRAIN_TMR:  src_level = training_timer_flag;
      sled_pkg::SRC_LOC_RCVR:   src_level = local_receiver_ok;
      sled_pkg::SRC_REM_RCVR:   src_level = remote_receiver_ok;
      sled_pkg::SRC_REF_CLK:    src_level = clk_sync_ff[0];
      sled_pkg::SRC_TX_CLK:     src_level = clk_sync_ff[1];
      sled_pkg::SRC_FAST_CLK:   src_level = clk_sync_ff[2];
      default:                  src_level = 1'b0;
    endcase
  end

  // pin registers
  logic pin_ff;
  logic pin_oe_ff;
  wire  nxt_pin    = indicator_enable & src_level;
  wire  nxt_pin_oe = (pinmux_select != sled_pkg::PINMUX_OFF);

  // enable gates after selection so a disabled pin is dark for every source
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_ff <= 1'b0;
    end else begin
      pin_ff <= nxt_pin;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pin_oe_ff <= 1'b0;
    end else begin
      pin_oe_ff <= nxt_pin_oe;
    end
  end

  assign second_indicator_pin    = pin_ff;
  assign second_indicator_pin_oe = pin_oe_ff;
  assign reg_rdata               = rdata_ff;

endmodule : sled_ctrl

// file: test/sled_led_model.sv
// status indicator controller: external indicator lamp on the pin
// assumes pin high means lit and an undriven pin leaves the lamp dark
`timescale 1ns/10ps
module sled_led_model (
  input  wire logic pin,
  input  wire logic pin_oe,
  output logic      lit
);
  // a released pin floats; dark lamp instead of guessing a level
  assign lit = pin_oe & pin;
endmodule : sled_led_model

// file: test/sled_ctrl_sva.sv
// status indicator controller: port assertions for sled_ctrl
// assumes it is bound to sled_ctrl and shadows the register pair itself
`timescale 1ns/10ps
module sled_ctrl_sva #(
  parameter int TICK_CYCLES = sled_pkg::TICK_CYCLES
) (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr_en,
  input wire logic [15:0] reg_rdata,
  input wire logic [2:0]  pinmux_select,
  input wire logic        link_up,
  input wire logic        send_traffic,
  input wire logic        recv_traffic,
  input wire logic        high_swing_level,
  input wire logic        role_resolution_fault,
  input wire logic        mismatched_link_setup,
  input wire logic        second_indicator_pin,
  input wire logic        second_indicator_pin_oe
);
  logic [15:0] blink_ff, ctrl_ff, exp_rd;
  logic [31:0] hi_run_ff, lo_run_ff, on_lim, off_lim;
  logic [4:0]  src;
  logic        en, qual, act, blink_m0, blink_m1;
  assign en = ctrl_ff[15];
  assign qual = ctrl_ff[14];
  assign src = ctrl_ff[12:8];
  assign act = send_traffic | recv_traffic;
  assign on_lim = 32'(blink_ff[15:8]) * TICK_CYCLES;
  assign off_lim = 32'(blink_ff[7:0]) * TICK_CYCLES;
  // graded mode leaves lengths alone only for short fields
  assign blink_m0 = en && !ctrl_ff[13] && src == 5'h0F && blink_ff[15:8] > 8'h01;
  assign blink_m1 = en && ctrl_ff[13] && src == 5'h0F && blink_ff[15:8] > 8'h01 && blink_ff[15:8] < 8'h10
                    && blink_ff[7:0] > 8'h01 && blink_ff[7:0] < 8'h08;
  assign exp_rd = (reg_addr == sled_pkg::REG_BLINK_ADDR) ? blink_ff :
                  (reg_addr == sled_pkg::REG_CTRL_ADDR) ? ctrl_ff : sled_pkg::READ_NONE;
  always_ff @(posedge clock) begin
    if (reset) begin
      blink_ff <= sled_pkg::BLINK_RESET;
      ctrl_ff  <= sled_pkg::CTRL_RESET;
    end else if (reg_wr_en && reg_addr == sled_pkg::REG_BLINK_ADDR) begin
      blink_ff <= reg_wdata;
    end else if (reg_wr_en && reg_addr == sled_pkg::REG_CTRL_ADDR) begin
      ctrl_ff <= reg_wdata;
    end
  end
  // run lengths restart on writes: a partial first interval is never judged
  always_ff @(posedge clock) begin
    if (reset || reg_wr_en) begin
      hi_run_ff <= '0;
      lo_run_ff <= '0;
    end else begin
      hi_run_ff <= second_indicator_pin ? hi_run_ff + 32'h1 : '0;
      lo_run_ff <= second_indicator_pin ? '0 : lo_run_ff + 32'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_hold_src(logic [4:0] c);
    (en && src == c) [*2];
  endsequence
  oe_mux_a: assert property (!$past(reset) |=> second_indicator_pin_oe == ($past(pinmux_select) != 3'h7))
    else $error("pin enable wrong for mux select");
  read_back_a: assert property (!$past(reset) |=> reg_rdata == $past(exp_rd))
    else $error("read data wrong");
  disable_off_a: assert property (!en [*3] |-> !second_indicator_pin)
    else $error("pin lit while disabled");
  role_fault_a: assert property (s_hold_src(5'h1D) |=> second_indicator_pin == $past(role_resolution_fault))
    else $error("status pin wrong");
  qual_gate_a: assert property (s_hold_src(5'h10) |=>
    second_indicator_pin == $past(high_swing_level && (link_up || !qual))) else $error("gating wrong");
  ungated_a: assert property (s_hold_src(5'h14) |=> second_indicator_pin == $past(mismatched_link_setup))
    else $error("ungated status pin wrong");
  live_follow_a: assert property ((en && src == 5'h04 && blink_ff == 16'h0000 && $stable(act)) [*3]
    |-> second_indicator_pin == act) else $error("live pin wrong");
  on_time_a: assert property ($fell(second_indicator_pin) && blink_m0 |-> hi_run_ff <= on_lim)
    else $error("on interval too long");
  off_time_a: assert property ($rose(second_indicator_pin) && blink_m1 |-> lo_run_ff <= off_lim)
    else $error("off interval too long");
endmodule : sled_ctrl_sva

// file: test/tb_top.sv
// status indicator controller: self-checking bench, seeded random plus corners
// assumes design under design/, checker and lamp model under test/
`timescale 1ns/10ps
module tb_top;
  localparam int T = 8;
  logic        clock, reset, reg_wr_en, pin, pin_oe, lit;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, st;
  logic [2:0]  pinmux_select;
  logic [31:0] seed;
  int          num_errors, cmp_count;
  int          codes[23] = '{0, 1, 2, 3, 4, 5, 6, 13, 14, 16, 17, 18, 19, 20, 21, 22, 23, 24, 25, 26, 27, 28, 29};
  sled_ctrl #(.TICK_CYCLES(T)) dut (
    .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr_en(reg_wr_en),
    .reg_rdata(reg_rdata), .pinmux_select(pinmux_select), .link_up(st[0]), .send_traffic(st[1]),
    .recv_traffic(st[2]), .high_swing_level(st[3]), .low_swing_level(st[4]), .role_leader(st[5]),
    .role_resolution_fault(st[6]), .mismatched_link_setup(st[7]), .negotiated_link_good(st[8]),
    .negotiation_done(st[9]), .training_timer_flag(st[10]), .local_receiver_ok(st[11]),
    .remote_receiver_ok(st[12]), .ref_clock_out_src(st[13]), .transmit_clock_out_src(st[14]),
    .fast_clock_out_src(st[15]), .second_indicator_pin(pin), .second_indicator_pin_oe(pin_oe));
  sled_led_model lamp (.pin(pin), .pin_oe(pin_oe), .lit(lit));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // codes 20..28 sit in order on st[7]..st[15]
  function automatic logic exp_pin(logic [4:0] c, logic q, logic [15:0] s);
    logic g;
    g = s[0] | ~q;
    case (c)
      5'h00: return s[0] & ~(s[1] | s[2]);
      5'h01: return s[0] & ~s[1];
      5'h02: return s[0] & ~s[2];
      5'h03: return s[0];
      5'h04: return s[1] | s[2];
      5'h05: return s[1];
      5'h06: return s[2];
      5'h0D: return 1'b1;
      5'h0E: return 1'b0;
      5'h10: return s[3] & g;
      5'h11: return s[4] & g;
      5'h12: return s[5] & g;
      5'h13: return ~s[5] & g;
      5'h1D: return s[6];
      default: return s[c - 5'h0D];
    endcase
  endfunction : exp_pin
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task automatic results();
    $display("mismatches %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results
  task automatic wr(logic [15:0] a, logic [15:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clock);
    reg_wr_en = 1'b0;
  endtask : wr
  task automatic rd_chk(logic [15:0] a, logic [15:0] e);
    @(negedge clock);
    reg_addr = a;
    @(negedge clock);
    check("reg_rdata", e, reg_rdata);
  endtask : rd_chk
  // bounded wait for the lamp to reach v, cycles counted in n
  task automatic wait_lit(logic v, output int n);
    n = 0;
    while (lit !== v && n < 2000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 2000) begin
      num_errors++;
      results();
    end
  endtask : wait_lit
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    logic [15:0] d;
    logic [4:0]  c;
    logic        q;
    int          n;
    {reset, reg_wr_en, reg_addr, reg_wdata, pinmux_select, st} = {1'b1, 1'b0, 16'h0000, 16'h0000, 3'h0, 16'h0000};
    seed = 32'hA99D;
    num_errors = 0;
    cmp_count = 0;
    repeat (4) @(negedge clock);
    reset = 1'b0;
    rd_chk(sled_pkg::REG_BLINK_ADDR, sled_pkg::BLINK_RESET);
    rd_chk(sled_pkg::REG_CTRL_ADDR, sled_pkg::CTRL_RESET);
    for (int i = 0; i < 6; i++) begin
      d = 16'(rnd());
      wr(sled_pkg::REG_BLINK_ADDR, d);
      rd_chk(sled_pkg::REG_BLINK_ADDR, d);
    end
    wr(16'h8C83, 16'hFFFF);
    rd_chk(16'h8C83, 16'h0000);
    rd_chk(sled_pkg::REG_BLINK_ADDR, d);
    wr(sled_pkg::REG_CTRL_ADDR, 16'h8D80);
    pinmux_select = 3'h7;
    repeat (3) @(negedge clock);
    check("lit", 1'b0, lit);
    pinmux_select = 3'h0;
    repeat (3) @(negedge clock);
    check("lit", 1'b1, lit);
    wr(sled_pkg::REG_CTRL_ADDR, 16'h0D80);
    repeat (3) @(negedge clock);
    check("lit", 1'b0, lit);
    wr(sled_pkg::REG_BLINK_ADDR, 16'h0000);
    repeat (3 * T) @(negedge clock);
    for (int i = 0; i < 92; i++) begin
      c = 5'(codes[i % 23]);
      q = 1'(rnd());
      wr(sled_pkg::REG_CTRL_ADDR, {1'b1, q, 1'b0, c, 8'h80});
      st = 16'(rnd());
      repeat (6) @(negedge clock);
      check("lit", exp_pin(c, q, st), lit);
    end
    st = 16'h0000;
    wr(sled_pkg::REG_BLINK_ADDR, 16'h0405);
    wr(sled_pkg::REG_CTRL_ADDR, 16'h8D80);
    repeat (3) @(negedge clock);
    wr(sled_pkg::REG_CTRL_ADDR, 16'h8F00);
    repeat (3) @(negedge clock);
    check("lit", 1'b0, lit);
    wait_lit(1'b1, n);
    wait_lit(1'b0, n);
    check("on_len", 4 * T, n);
    wait_lit(1'b1, n);
    check("off_len", 5 * T, n);
    wr(sled_pkg::REG_CTRL_ADDR, 16'h8E00);
    repeat (3) @(negedge clock);
    wr(sled_pkg::REG_CTRL_ADDR, 16'hAF00);
    repeat (3) @(negedge clock);
    check("lit", 1'b1, lit);
    wait_lit(1'b0, n);
    wait_lit(1'b1, n);
    check("off_len", 5 * T, n);
    // park the engine first, then traffic on: blink at the programmed rate; traffic off: settle dark
    wr(sled_pkg::REG_CTRL_ADDR, 16'h8E00);
    wr(sled_pkg::REG_CTRL_ADDR, 16'h8480);
    st = 16'h0002;
    wait_lit(1'b1, n);
    wait_lit(1'b0, n);
    check("on_len", 4 * T, n);
    st = 16'h0000;
    repeat (30 * T) @(negedge clock);
    check("lit", 1'b0, lit);
    results();
  end
endmodule : tb_top
bind sled_ctrl sled_ctrl_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
  .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr_en(reg_wr_en),
  .reg_rdata(reg_rdata), .pinmux_select(pinmux_select), .link_up(link_up), .send_traffic(send_traffic),
  .recv_traffic(recv_traffic), .high_swing_level(high_swing_level),
  .role_resolution_fault(role_resolution_fault), .mismatched_link_setup(mismatched_link_setup),
  .second_indicator_pin(second_indicator_pin), .second_indicator_pin_oe(second_indicator_pin_oe));
